//--- paired_timer_control.sv
// Paired low/high word timer with APB register access and one interrupt.
// Assumes idle_mode comes from logic on pclk and the count pins are async.
//
// What this block does
// - In 16-bit mode the run bit starts a timer's count; clearing it halts.
// - Joined as 32 bits, the low-word control register steers the pair; the high word adds only idle-halt.
// - Pairing select set joins counters into 32 bits; clear keeps two 16-bit.
// - Idle-halt set stops the timer in Idle; clear keeps it running.
// - With external clock selected the gate enable bit is ignored.
// - With internal clock, gate bit set counts only while the gate is high.
// - Prescale codes 11, 10, 01, 00 divide by 256, 64, 8 and 1.
// - Clock source set counts rising edges of the external count pin.
// - Unused control bits read zero and ignore writes.
// - Joined counter interrupts through high-word status; low-word one ignored.
// - High-word idle-halt bit still acts when the pair is joined.
// - Joined, the high word holds the upper and low word the lower 16 bits.
//
// The register addresses and the APB slave port are this design's own decisions.
module paired_timer_control #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System and pins
  input wire logic idle_mode,
  input wire logic ext_count_input_lo,
  input wire logic ext_count_input_hi,
  // Interrupt
  output logic irq
);
  import paired_timer_pkg::*;

  initial begin
    if (ADDR_W < 8) begin
      $error("paired_timer_control: ADDR_W must be at least 8");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl_lo_r;
    logic [15:0] ctrl_hi_r;
    logic [15:0] cnt_lo_r;
    logic [15:0] cnt_hi_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [31:0] rdata_r;
    logic half_r;
  } tmr_state_t;

  tmr_state_t s_r;
  tmr_state_t s_nxt;

  logic [7:0] addr8;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic hit;
  logic join_mode;
  logic run_lo;
  logic run_hi;
  logic src_lo;
  logic src_hi;
  logic tick_lo;
  logic tick_hi;
  logic wrap_lo;
  logic wrap_hi;
  logic [1:0] ev;
  logic lvl_lo;
  logic lvl_hi;
  logic rise_lo;
  logic rise_hi;
  logic clr_lo;
  logic clr_hi;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      OFS_CTRL_LO, OFS_CTRL_HI, OFS_CNT_LO,
      OFS_CNT_HI, OFS_IRQ_STAT, OFS_IRQ_MASK: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  // Source tick for one timer from its own control fields.
  function automatic logic src_tick(input logic [15:0] c, input logic half,
                                    input logic rise, input logic gate);
    if (c[BIT_CLK_SRC]) begin
      src_tick = rise;
    end else if (c[BIT_GATE]) begin
      src_tick = half & gate;
    end else begin
      src_tick = half;
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and prescalers
  // ----------------------------------------------------------------
  ext_input_sync u_sync_lo (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_in(ext_count_input_lo),
    .level_out(lvl_lo),
    .rise_out(rise_lo)
  );

  ext_input_sync u_sync_hi (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_in(ext_count_input_hi),
    .level_out(lvl_hi),
    .rise_out(rise_hi)
  );

  tick_prescaler #(.WIDTH(8)) u_ps_lo (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .clr(clr_lo),
    .sel(prescale_t'(s_r.ctrl_lo_r[BIT_PS_HI:BIT_PS_LO])),
    .tick_in(src_lo),
    .tick_out(tick_lo)
  );

  tick_prescaler #(.WIDTH(8)) u_ps_hi (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .clr(clr_hi),
    .sel(prescale_t'(s_r.ctrl_hi_r[BIT_PS_HI:BIT_PS_LO])),
    .tick_in(src_hi),
    .tick_out(tick_hi)
  );

  // ----------------------------------------------------------------
  // Count control
  // ----------------------------------------------------------------
  assign addr8 = paddr[7:0];
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit = addr_hit(addr8) && (paddr >> 8) == '0;
  assign wr = access & pwrite & hit;
  assign rd = access & ~pwrite & hit;
  assign join_mode = s_r.ctrl_lo_r[BIT_JOIN];

  // Joined, the high-word register only contributes its idle-halt bit.
  assign run_lo = s_r.ctrl_lo_r[BIT_RUN]
                  & ~(idle_mode & s_r.ctrl_lo_r[BIT_IDLE_HALT])
                  & ~(join_mode & idle_mode & s_r.ctrl_hi_r[BIT_IDLE_HALT]);
  assign run_hi = ~join_mode & s_r.ctrl_hi_r[BIT_RUN]
                  & ~(idle_mode & s_r.ctrl_hi_r[BIT_IDLE_HALT]);

  assign src_lo = run_lo & src_tick(s_r.ctrl_lo_r, s_r.half_r, rise_lo, lvl_lo);
  assign src_hi = run_hi & src_tick(s_r.ctrl_hi_r, s_r.half_r, rise_hi, lvl_hi);

  // A control write restarts the prescaler so a new ratio starts clean.
  assign clr_lo = wr && addr8 == OFS_CTRL_LO;
  assign clr_hi = wr && addr8 == OFS_CTRL_HI;

  assign wrap_lo = tick_lo && s_r.cnt_lo_r == CNT_MAX;
  assign wrap_hi = join_mode ? (wrap_lo && s_r.cnt_hi_r == CNT_MAX)
                             : (tick_hi && s_r.cnt_hi_r == CNT_MAX);
  assign ev[IRQ_LO] = ~join_mode & wrap_lo;
  assign ev[IRQ_HI] = wrap_hi;

  always_comb begin
    s_nxt = s_r;
    s_nxt.half_r = ~s_r.half_r;
    if (tick_lo) begin
      s_nxt.cnt_lo_r = 16'(s_r.cnt_lo_r + 16'h0001);
    end
    // Joined, the high word carries from the low word.
    if (join_mode ? wrap_lo : tick_hi) begin
      s_nxt.cnt_hi_r = 16'(s_r.cnt_hi_r + 16'h0001);
    end
    // A read clears status; an event in the same cycle still lands.
    if (rd && addr8 == OFS_IRQ_STAT) begin
      s_nxt.irq_stat_r = ev;
    end else begin
      s_nxt.irq_stat_r = s_r.irq_stat_r | ev;
    end
    if (wr) begin
      case (addr8)
        OFS_CTRL_LO: s_nxt.ctrl_lo_r = pwdata[15:0] & CTRL_LO_MASK;
        OFS_CTRL_HI: s_nxt.ctrl_hi_r = pwdata[15:0] & CTRL_HI_MASK;
        OFS_CNT_LO: s_nxt.cnt_lo_r = pwdata[15:0];
        OFS_CNT_HI: s_nxt.cnt_hi_r = pwdata[15:0];
        OFS_IRQ_MASK: s_nxt.irq_mask_r = pwdata[1:0];
        default: s_nxt.irq_mask_r = s_r.irq_mask_r;
      endcase
    end
    // Read data is latched in the setup cycle so a zero-wait access is valid.
    if (setup && !pwrite) begin
      case (addr8)
        OFS_CTRL_LO: s_nxt.rdata_r = {16'h0000, s_r.ctrl_lo_r};
        OFS_CTRL_HI: s_nxt.rdata_r = {16'h0000, s_r.ctrl_hi_r};
        OFS_CNT_LO: s_nxt.rdata_r = {16'h0000, s_r.cnt_lo_r};
        OFS_CNT_HI: s_nxt.rdata_r = {16'h0000, s_r.cnt_hi_r};
        OFS_IRQ_STAT: s_nxt.rdata_r = {30'h0, s_r.irq_stat_r};
        OFS_IRQ_MASK: s_nxt.rdata_r = {30'h0, s_r.irq_mask_r};
        default: s_nxt.rdata_r = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.ctrl_lo_r <= CTRL_RESET;
      s_r.ctrl_hi_r <= CTRL_RESET;
      s_r.cnt_lo_r <= CNT_RESET;
      s_r.cnt_hi_r <= CNT_RESET;
      s_r.irq_stat_r <= IRQ_RESET;
      s_r.irq_mask_r <= IRQ_RESET;
      s_r.rdata_r <= 32'h00000000;
      s_r.half_r <= 1'b0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // Status read between the setup latch and the access may miss one event
  // in the returned word; the clear in the access cycle then drops it from the sticky bit.
  assign prdata = s_r.rdata_r;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign irq = |(s_r.irq_stat_r & s_r.irq_mask_r);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic cnt_lo_wr;
  logic cnt_hi_wr;
  assign cnt_lo_wr = wr && addr8 == OFS_CNT_LO;
  assign cnt_hi_wr = wr && addr8 == OFS_CNT_HI;

  property p_halt_holds;
    @(posedge pclk) disable iff (!presetn)
      (!join_mode && !s_r.ctrl_lo_r[BIT_RUN] && !cnt_lo_wr)
      |=> $stable(s_r.cnt_lo_r);
  endproperty
  a_halt_holds: assert property (p_halt_holds)
    else $error("low counter moved while halted");

  property p_join_ignores_hi;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && join_mode && !wrap_lo && !cnt_hi_wr) |=> $stable(s_r.cnt_hi_r);
  endproperty
  a_join_ignores_hi: assert property (p_join_ignores_hi)
    else $error("high timer ran in joined mode");

  property p_join_carry;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && join_mode && wrap_lo && !cnt_hi_wr && !cnt_lo_wr
       && s_r.cnt_hi_r != CNT_MAX)
      |=> s_r.cnt_hi_r == $past(s_r.cnt_hi_r) + 16'h0001 && s_r.cnt_lo_r == 16'h0000;
  endproperty
  a_join_carry: assert property (p_join_carry)
    else $error("low word wrap did not carry into high word");

  property p_idle_halt;
    @(posedge pclk) disable iff (!presetn)
      (idle_mode && s_r.ctrl_lo_r[BIT_IDLE_HALT]) |-> !tick_lo;
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("timer ticked in idle with halt set");

  property p_ext_src;
    @(posedge pclk) disable iff (!presetn)
      s_r.ctrl_lo_r[BIT_CLK_SRC] |-> src_lo == (run_lo & rise_lo);
  endproperty
  a_ext_src: assert property (p_ext_src)
    else $error("external source not tracking pin edges");

  property p_gate_closed;
    @(posedge pclk) disable iff (!presetn)
      (!s_r.ctrl_lo_r[BIT_CLK_SRC] && s_r.ctrl_lo_r[BIT_GATE] && !lvl_lo) |-> !src_lo;
  endproperty
  a_gate_closed: assert property (p_gate_closed)
    else $error("gated timer counted with gate low");

  sequence s_div8_tick;
    tick_lo && s_r.ctrl_lo_r[BIT_PS_HI:BIT_PS_LO] == PS_DIV8 && !clr_lo;
  endsequence
  sequence s_quiet7;
    !tick_lo [*7];
  endsequence
  property p_div8_gap;
    @(posedge pclk) disable iff (!presetn)
      s_div8_tick |=> s_quiet7;
  endproperty
  a_div8_gap: assert property (p_div8_gap)
    else $error("divide-by-8 prescaler ticked early");

  property p_int_rate;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && src_lo && !s_r.ctrl_lo_r[BIT_CLK_SRC]) |=> !src_lo;
  endproperty
  a_int_rate: assert property (p_int_rate)
    else $error("internal clock faster than half rate");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      (s_r.ctrl_lo_r & ~CTRL_LO_MASK) == 16'h0000
      && (s_r.ctrl_hi_r & ~CTRL_HI_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bit set");

  property p_join_irq;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && join_mode && wrap_hi) |=> s_r.irq_stat_r[IRQ_HI];
  endproperty
  a_join_irq: assert property (p_join_irq)
    else $error("joined wrap did not flag high-word status");

  property p_reset_ctrl;
    @(posedge pclk) $rose(presetn) |-> s_r.ctrl_lo_r == CTRL_RESET
      && s_r.ctrl_hi_r == CTRL_RESET;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl)
    else $error("control not cleared by reset");
endmodule // paired_timer_control

//--- paired_timer_pkg.sv
// Constants, field layout and register map of the paired timer block.
// Assumes a 100 MHz APB clock and a 32-bit APB data path.
package paired_timer_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int unsigned PCLK_FREQ_HZ = 100_000_000;
  localparam int unsigned PCLK_PERIOD_NS = 1_000_000_000 / PCLK_FREQ_HZ;
  // The internal count clock runs at half the oscillator rate.
  localparam int unsigned INT_CLK_DIV = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_LO = 8'h00;
  localparam logic [7:0] OFS_CTRL_HI = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_RUN = 15;
  localparam int unsigned BIT_IDLE_HALT = 13;
  localparam int unsigned BIT_GATE = 6;
  localparam int unsigned BIT_PS_HI = 5;
  localparam int unsigned BIT_PS_LO = 4;
  localparam int unsigned BIT_JOIN = 3;
  localparam int unsigned BIT_CLK_SRC = 1;
  localparam logic [15:0] CTRL_LO_MASK = 16'ha07a;
  localparam logic [15:0] CTRL_HI_MASK = 16'ha072;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // Interrupt status and mask layout
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_LO = 0;
  localparam int unsigned IRQ_HI = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Prescaler codes and terminal counts (ratio minus one)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PS_DIV1 = 2'h0,
    PS_DIV8 = 2'h1,
    PS_DIV64 = 2'h2,
    PS_DIV256 = 2'h3
  } prescale_t;
  localparam logic [7:0] PS_TERM_DIV1 = 8'h00;
  localparam logic [7:0] PS_TERM_DIV8 = 8'h07;
  localparam logic [7:0] PS_TERM_DIV64 = 8'h3f;
  localparam logic [7:0] PS_TERM_DIV256 = 8'hff;

endpackage

//--- ext_input_sync.sv
// Two-flop synchroniser for an external count pin, with rising-edge detect.
// Assumes the pin is asynchronous to pclk and slower than half its rate.
module ext_input_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Pin and synchronised views
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out
);
  import paired_timer_pkg::*;

  typedef struct packed {
    logic meta_r;
    logic sync_r;
    logic prev_r;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.meta_r = pin_in;
    s_nxt.sync_r = s_r.meta_r;
    s_nxt.prev_r = s_r.sync_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // The edge is taken between the second and third flop only.
  assign level_out = s_r.sync_r;
  assign rise_out = s_r.sync_r & ~s_r.prev_r & clk_en;
endmodule // ext_input_sync

//--- tick_prescaler.sv
// Input clock prescaler: passes one tick in 1, 8, 64 or 256.
// Assumes tick_in is a one-cycle enable on pclk.
module tick_prescaler #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Control
  input wire logic clr,
  input wire paired_timer_pkg::prescale_t sel,
  // Ticks
  input wire logic tick_in,
  output logic tick_out
);
  import paired_timer_pkg::*;

  initial begin
    if (WIDTH != 8) begin
      $error("tick_prescaler: WIDTH must be 8");
    end
  end

  typedef struct packed {
    logic [7:0] cnt_r;
  } ps_state_t;

  ps_state_t s_r;
  ps_state_t s_nxt;
  logic [7:0] term;
  logic at_term;

  function automatic logic [7:0] term_of(input prescale_t code);
    case (code)
      PS_DIV1: term_of = PS_TERM_DIV1;
      PS_DIV8: term_of = PS_TERM_DIV8;
      PS_DIV64: term_of = PS_TERM_DIV64;
      PS_DIV256: term_of = PS_TERM_DIV256;
      default: term_of = PS_TERM_DIV1;
    endcase
  endfunction

  always_comb begin
    term = term_of(sel);
    at_term = (s_r.cnt_r >= term);
    s_nxt = s_r;
    if (clr) begin
      s_nxt.cnt_r = '0;
    end else if (tick_in) begin
      s_nxt.cnt_r = at_term ? 8'h00 : 8'(s_r.cnt_r + 8'h01);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign tick_out = tick_in & at_term & ~clr & clk_en;
endmodule // tick_prescaler

//--- paired_timer_control_tb.sv
// Self-checking bench for the paired timer: APB access, count modes,
// pairing and the interrupt. All pins are driven here; clk_en is dropped once for the freeze check.
module paired_timer_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import paired_timer_pkg::*;
  // ----------------------------------------
  // Signals and bench model state
  // ----------------------------------------
  localparam logic [15:0] RUN = 16'h1 << BIT_RUN;
  localparam logic [15:0] IDL = 16'h1 << BIT_IDLE_HALT;
  localparam logic [15:0] GAT = 16'h1 << BIT_GATE;
  localparam logic [15:0] JN = 16'h1 << BIT_JOIN;
  localparam logic [15:0] CS = 16'h1 << BIT_CLK_SRC;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic idle_mode = 1'b0;
  logic pin_lo = 1'b0;
  logic pin_hi = 1'b0;
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int divs[4] = '{1, 8, 64, 256};
  logic [7:0] ofs[6] = '{OFS_CTRL_LO, OFS_CTRL_HI, OFS_CNT_LO, OFS_CNT_HI,
                         OFS_IRQ_STAT, OFS_IRQ_MASK};
  logic [15:0] msk[2] = '{CTRL_LO_MASK, CTRL_HI_MASK};
  logic [15:0] ctrl_m[2];

  paired_timer_control dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .ext_count_input_lo(pin_lo),
    .ext_count_input_hi(pin_hi), .irq(irq));

  initial begin
    forever #5 pclk = ~pclk;
  end

  // A hang is cut short well above the longest prescaler run.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    checks++;
    if (sn !== ex) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, ex, sn);
    end
  endtask

  // Request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rd);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask

  // Tick phase at start and stop leaves one count of slack.
  task automatic rdn(input logic [7:0] a, input int ex, input string nm);
    logic [31:0] e;
    apb(1'b0, a, 32'h0);
    e = ex;
    if (rd === e + 32'h1 || rd === e - 32'h1)
      e = rd;
    chk(nm, e, rd);
  endtask

  // Counting window is n + 3 cycles between the two control writes.
  task automatic run_for(input logic [7:0] ca, input logic [15:0] c, input int n);
    wr(ca, c | RUN);
    repeat (n) @(posedge pclk);
    wr(ca, c);
  endtask

  task automatic irq_is(input logic ex);
    @(negedge pclk);
    chk("irq", {31'h0, ex}, {31'h0, irq});
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    int n;
    int k;
    logic [31:0] d;
    logic [31:0] v;
    void'($urandom(32'hd4c2));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rdchk(ofs[i], 32'h0, "reset value");
    $display("test reset finished");

    for (int i = 0; i < 2; i++) begin
      for (int j = 0; j < 2; j++) begin
        d = j ? $urandom() : 32'hffffffff;
        apb(1'b1, ofs[i], d);
        ctrl_m[i] = d[15:0] & msk[i];
        rdchk(ofs[i], {16'h0, ctrl_m[i]}, "ctrl readback");
      end
      wr(ofs[i], 16'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("test register access finished");

    for (int c = 0; c < 4; c++) begin
      n = divs[c] * 2 * (3 + $urandom_range(4)) + $urandom_range(7);
      wr(OFS_CNT_LO, 16'h0);
      run_for(OFS_CTRL_LO, 16'(c) << BIT_PS_LO, n);
      rdn(OFS_CNT_LO, (n + 3) / (2 * divs[c]), "low count");
    end
    wr(OFS_CNT_LO, 16'h0);
    wr(OFS_CNT_HI, 16'h0);
    n = 30 + $urandom_range(60);
    run_for(OFS_CTRL_HI, 16'h0, n);
    rdchk(OFS_CNT_LO, 32'h0, "low idle while high runs");
    rdn(OFS_CNT_HI, (n + 3) / 2, "high count");
    $display("test prescale finished");

    idle_mode <= 1'b1;
    wr(OFS_CNT_LO, 16'h0);
    run_for(OFS_CTRL_LO, IDL, 40);
    rdchk(OFS_CNT_LO, 32'h0, "halted in idle");
    run_for(OFS_CTRL_LO, 16'h0, 40);
    rdn(OFS_CNT_LO, 21, "runs in idle");
    idle_mode <= 1'b0;
    // With the clock enable low the running counter must not move.
    wr(OFS_CNT_LO, 16'h0);
    wr(OFS_CTRL_LO, RUN);
    clk_en <= 1'b0;
    repeat (50) @(posedge pclk);
    clk_en <= 1'b1;
    wr(OFS_CTRL_LO, 16'h0);
    rdn(OFS_CNT_LO, 1, "frozen count");
    $display("test idle finished");

    wr(OFS_CNT_LO, 16'h0);
    wr(OFS_CTRL_LO, RUN | CS | GAT);
    k = 5 + $urandom_range(10);
    repeat (k) begin
      pin_lo <= 1'b1;
      repeat (4) @(posedge pclk);
      pin_lo <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
    wr(OFS_CTRL_LO, 16'h0);
    rdchk(OFS_CNT_LO, k, "external edges");
    wr(OFS_CNT_LO, 16'h0);
    wr(OFS_CTRL_LO, RUN | GAT);
    repeat (20) @(posedge pclk);
    k = 20 + 2 * $urandom_range(40);
    pin_lo <= 1'b1;
    repeat (k) @(posedge pclk);
    pin_lo <= 1'b0;
    repeat (10) @(posedge pclk);
    wr(OFS_CTRL_LO, 16'h0);
    rdn(OFS_CNT_LO, k / 2, "gated count");
    $display("test clock source finished");

    wr(OFS_IRQ_MASK, 16'h3);
    wr(OFS_CTRL_LO, JN);
    wr(OFS_CTRL_HI, RUN);
    wr(OFS_CNT_LO, 16'hfff0);
    wr(OFS_CNT_HI, 16'hffff);
    run_for(OFS_CTRL_LO, JN, 60);
    irq_is(1'b1);
    rdn(OFS_CNT_LO, 15, "joined low word");
    v = rd;
    rdchk(OFS_CNT_HI, 32'h0, "joined high word");
    rdchk(OFS_IRQ_STAT, 32'h2, "joined status");
    irq_is(1'b0);
    repeat (40) @(posedge pclk);
    rdchk(OFS_CNT_LO, v, "high run ignored");
    wr(OFS_CTRL_HI, IDL);
    idle_mode <= 1'b1;
    run_for(OFS_CTRL_LO, JN, 40);
    rdchk(OFS_CNT_LO, v, "high idle halt");
    idle_mode <= 1'b0;
    wr(OFS_CTRL_HI, 16'h0);
    wr(OFS_CTRL_LO, 16'h0);
    $display("test joined finished");

    wr(OFS_IRQ_MASK, 16'h0);
    wr(OFS_CNT_LO, 16'hfffc);
    run_for(OFS_CTRL_LO, 16'h0, 20);
    irq_is(1'b0);
    wr(OFS_IRQ_MASK, 16'h1);
    irq_is(1'b1);
    rdchk(OFS_IRQ_STAT, 32'h1, "low wrap status");
    irq_is(1'b0);
    rdchk(OFS_IRQ_STAT, 32'h0, "status cleared");
    $display("test interrupt finished");
    give_verdict();
  end
endmodule // paired_timer_control_tb
